// file: verilog/bst_pkg.sv
/*
  constants, state encoding and instruction codes for the boundary-scan test port.
  assumes one system clock; the test clock is sampled as an ordinary input.
*/
// What this block does
// RULE_01: instruction register is three bits, shifted from test input to output in ir-shift.
// RULE_02: sample/preload captures pin values into the boundary register, core untouched.
// RULE_03: sample/preload lets a shifted pattern be preloaded for later pin driving.
// RULE_04: external test drives the pattern onto pins and captures pin values.
// RULE_05: bypass puts a one-bit register between test input and output.
// RULE_06: boundary register length is a per-variant parameter: 273, 417, 465 or 645.
// RULE_07: undriven test inputs read as logic high through weak pull-ups.
// RULE_08: standard sixteen-state controller; test output driven only in shift states.
package bst_pkg;
  // ==========================================================
  // sizes
  localparam int IR_LEN = 3;
  localparam int BSR_LEN_DEF = 273;
  localparam int SYNC_STAGES = 2;
  localparam int RESET_TMS_CNT = 5;
  // ==========================================================
  // instruction codes
  localparam logic [IR_LEN-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 3'h5;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 3'h7;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic [IR_LEN-1:0] IR_RESET_VAL = OP_BYPASS;
  // ==========================================================
  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET     = 16'h0001,
    ST_IDLE      = 16'h0002,
    ST_SEL_DR    = 16'h0004,
    ST_CAP_DR    = 16'h0008,
    ST_SHIFT_DR  = 16'h0010,
    ST_EXIT1_DR  = 16'h0020,
    ST_PAUSE_DR  = 16'h0040,
    ST_EXIT2_DR  = 16'h0080,
    ST_UPD_DR    = 16'h0100,
    ST_SEL_IR    = 16'h0200,
    ST_CAP_IR    = 16'h0400,
    ST_SHIFT_IR  = 16'h0800,
    ST_EXIT1_IR  = 16'h1000,
    ST_PAUSE_IR  = 16'h2000,
    ST_EXIT2_IR  = 16'h4000,
    ST_UPD_IR    = 16'h8000
  } bst_state_t;
endpackage

// file: verilog/bst_tap_if.sv
/*
  carrier between the controller and the scan registers.
  assumes both ends run on the system clock.
*/
`timescale 1ns/10ps
interface bst_tap_if;
  logic rise;                  // test clock rising edge pulse
  logic fall;                  // test clock falling edge pulse
  logic tdi;                   // synchronised test data
  bst_pkg::bst_state_t state;  // controller state
  modport ctrl (output rise, output fall, output tdi, output state);
  modport user (input rise, input fall, input tdi, input state);
endinterface

// file: verilog/bst_tap_ctrl.sv
/*
  test access port controller: pin synchronisers, edge finder, sixteen-state machine.
  assumes the test clock is at least four system clocks per half period.
*/
`timescale 1ns/10ps
module bst_tap_ctrl (
  input wire logic clk,       // system clock
  input wire logic rst_n,     // async reset, active low
  input wire logic tck,       // test clock pin
  input wire logic tms,       // mode select pin level
  input wire logic tms_en,    // high while tester drives mode select
  input wire logic tdi,       // data pin level
  input wire logic tdi_en,    // high while tester drives data
  bst_tap_if.ctrl tap         // to scan registers
);
  // ==========================================================
  // synchronisers
  logic [1:0] tck_s;
  logic [1:0] tms_s;
  logic [1:0] tdi_s;
  logic [1:0] tms_en_s;
  logic [1:0] tdi_en_s;
  logic tck_d;
  logic tms_pu;
  logic tdi_pu;
  bst_pkg::bst_state_t next_state;

  // two flops per pin, drive flags too; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_s <= 2'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      tms_en_s <= 2'h0;
      tdi_en_s <= 2'h0;
      tck_d <= 1'b0;
    end else begin
      tck_s <= {tck_s[0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      tms_en_s <= {tms_en_s[0], tms_en};
      tdi_en_s <= {tdi_en_s[0], tdi_en};
      tck_d <= tck_s[1];
    end
  end

  // weak pull-up after the synchronisers: an undriven pin reads high
  // level and drive flag share one lag, so a release never shows a stale level
  assign tms_pu = tms_en_s[1] ? tms_s[1] : 1'b1; // RULE_07
  assign tdi_pu = tdi_en_s[1] ? tdi_s[1] : 1'b1; // RULE_07

  assign tap.rise = tck_s[1] & ~tck_d;
  assign tap.fall = ~tck_s[1] & tck_d;
  assign tap.tdi = tdi_pu;

  // ==========================================================
  // state machine
  // next state from mode select at the rising edge
  always_comb begin
    next_state = tap.state;
    case (tap.state) // RULE_08
      bst_pkg::ST_RESET: next_state = tms_pu ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: next_state = tms_pu ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: next_state = tms_pu ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: next_state = tms_pu ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: next_state = tms_pu ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: next_state = tms_pu ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: next_state = tms_pu ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: next_state = tms_pu ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR: next_state = tms_pu ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: next_state = tms_pu ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: next_state = tms_pu ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: next_state = tms_pu ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: next_state = tms_pu ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: next_state = tms_pu ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: next_state = tms_pu ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR: next_state = tms_pu ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: next_state = bst_pkg::ST_RESET;
    endcase
  end

  // state register, advanced only on a test clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap.state <= bst_pkg::ST_RESET;
    end else if (tap.rise) begin
      tap.state <= next_state; // RULE_08
    end
  end

  // ==========================================================
  // checks
  logic [2:0] ones_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ones_cnt <= 3'h0;
    end else if (tap.rise) begin
      ones_cnt <= !tms_pu ? 3'h0 : (ones_cnt == 3'h7 ? ones_cnt : ones_cnt + 3'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  five_ones_a: assert property (ones_cnt >= 3'(bst_pkg::RESET_TMS_CNT) // RULE_08
      |-> tap.state == bst_pkg::ST_RESET)
    else $error("five mode-select highs did not reach reset state");
  hold_state_a: assert property (!tap.rise |=> $stable(tap.state)) // RULE_08
    else $error("state moved without a test clock rise");
  pull_up_a: assert property (!tdi_en ##2 !tdi_en |-> tdi_pu) // RULE_07
    else $error("undriven data input did not read high");
endmodule

// file: verilog/bst_top.sv
/*
  boundary-scan test port top: instruction register, bypass, boundary register, pin muxing.
  assumes pins and test pins come from outside the clock domain; core outputs are on clk.
*/
`timescale 1ns/10ps
module bst_top #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_DEF  // cells per variant
) (
  input wire logic clk,                    // system clock
  input wire logic rst_n,                  // async reset, active low
  input wire logic tck,                    // test clock pin
  input wire logic tms,                    // mode select pin
  input wire logic tms_en,                 // tester drives mode select
  input wire logic tdi,                    // test data in pin
  input wire logic tdi_en,                 // tester drives data in
  output logic tdo,                        // test data out
  output logic tdo_oe,                     // test data out enable
  input wire logic [BSR_LEN-1:0] pin_in,   // levels seen at the pins
  input wire logic [BSR_LEN-1:0] core_out, // core values for the pins
  input wire logic [BSR_LEN-1:0] core_oe,  // core enables for the pins
  output logic [BSR_LEN-1:0] pin_out,      // value driven to pins
  output logic [BSR_LEN-1:0] pin_oe,       // pin drive enable
  output logic [bst_pkg::IR_LEN-1:0] ir    // active instruction
);
  // ==========================================================
  // controller
  bst_tap_if tap ();
  bst_tap_ctrl u_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .tck(tck),
    .tms(tms),
    .tms_en(tms_en),
    .tdi(tdi),
    .tdi_en(tdi_en),
    .tap(tap)
  );

  // only the four built chain lengths are legal; anything else still builds and is flagged
  // by the length check below at the first clock out of reset
  localparam bit LEN_OK = (BSR_LEN == 273) || (BSR_LEN == 417) || (BSR_LEN == 465) ||
    (BSR_LEN == 645);

  logic [BSR_LEN-1:0] pin_s1;
  logic [BSR_LEN-1:0] pin_s2;
  logic [BSR_LEN-1:0] bsr;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [bst_pkg::IR_LEN-1:0] ir_sh;
  logic bypass_bit;
  logic extest;
  logic use_bsr;
  logic shifting;
  logic next_tdo;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // ==========================================================
  // instruction register
  // shift chain and the held instruction; reset leaves bypass selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh <= bst_pkg::IR_RESET_VAL;
      ir <= bst_pkg::IR_RESET_VAL;
    end else if (tap.rise) begin
      if (tap.state == bst_pkg::ST_RESET) begin
        ir <= bst_pkg::IR_RESET_VAL;
      end else if (tap.state == bst_pkg::ST_CAP_IR) begin
        ir_sh <= bst_pkg::IR_CAPTURE_VAL;
      end else if (tap.state == bst_pkg::ST_SHIFT_IR) begin
        ir_sh <= {tap.tdi, ir_sh[bst_pkg::IR_LEN-1:1]}; // RULE_01
      end else if (tap.state == bst_pkg::ST_UPD_IR) begin
        ir <= ir_sh; // RULE_01
      end
    end
  end

  // unknown codes fall back to the bypass path
  assign extest = (ir == bst_pkg::OP_EXTEST);
  assign use_bsr = extest || (ir == bst_pkg::OP_SAMPLE);

  // ==========================================================
  // data registers
  // bypass captures zero then passes one bit per clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_bit <= 1'b0;
    end else if (tap.rise && !use_bsr) begin
      if (tap.state == bst_pkg::ST_CAP_DR) begin
        bypass_bit <= 1'b0;
      end else if (tap.state == bst_pkg::ST_SHIFT_DR) begin
        bypass_bit <= tap.tdi; // RULE_05
      end
    end
  end

  // boundary chain: capture pins, shift, update the latched pattern
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr <= '0;
      bsr_upd <= '0;
    end else if (tap.rise && use_bsr) begin
      if (tap.state == bst_pkg::ST_CAP_DR) begin
        bsr <= pin_s2; // RULE_02 RULE_04
      end else if (tap.state == bst_pkg::ST_SHIFT_DR) begin
        bsr <= {tap.tdi, bsr[BSR_LEN-1:1]}; // RULE_03
      end else if (tap.state == bst_pkg::ST_UPD_DR) begin
        bsr_upd <= bsr; // RULE_03
      end
    end
  end

  // pins follow the core unless external test owns them; registered to avoid glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= extest ? bsr_upd : core_out; // RULE_02 RULE_04
      pin_oe <= extest ? '1 : core_oe; // RULE_04
    end
  end

  // ==========================================================
  // test data output, changed on the falling test clock edge
  assign shifting = (tap.state == bst_pkg::ST_SHIFT_DR) || (tap.state == bst_pkg::ST_SHIFT_IR);

  always_comb begin
    next_tdo = bypass_bit;
    if (tap.state == bst_pkg::ST_SHIFT_IR) begin
      next_tdo = ir_sh[0]; // RULE_01
    end else if (use_bsr) begin
      next_tdo = bsr[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tap.fall) begin
      tdo <= next_tdo;
      tdo_oe <= shifting; // RULE_08
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence upd_ir_s;
    tap.rise && tap.state == bst_pkg::ST_UPD_IR;
  endsequence

  sequence shift_dr_s;
    tap.rise && tap.state == bst_pkg::ST_SHIFT_DR;
  endsequence

  len_ok_a: assert property (LEN_OK) // RULE_06
    else $error("boundary length is not a supported variant");
  ir_load_a: assert property (upd_ir_s |=> ir == $past(ir_sh)) // RULE_01
    else $error("instruction not loaded from shift chain");
  ir_shift_a: assert property (tap.rise && tap.state == bst_pkg::ST_SHIFT_IR
      |=> ir_sh[2] == $past(tap.tdi) && ir_sh[1:0] == $past(ir_sh[2:1])) // RULE_01
    else $error("instruction chain did not shift");
  sample_core_a: assert property (!extest ##1 !extest |-> pin_out == $past(core_out)) // RULE_02
    else $error("core outputs disturbed outside external test");
  preload_a: assert property (use_bsr && tap.rise && tap.state == bst_pkg::ST_UPD_DR
      |=> bsr_upd == $past(bsr)) // RULE_03
    else $error("preload pattern not latched");
  extest_drive_a: assert property (extest ##1 extest |-> pin_out == $past(bsr_upd)
      && pin_oe == '1) // RULE_04
    else $error("external test pattern not on pins");
  bypass_a: assert property (!use_bsr and shift_dr_s |=> bypass_bit == $past(tap.tdi)) // RULE_05
    else $error("bypass bit did not take test input");
  tdo_float_a: assert property (tap.fall && !shifting |=> !tdo_oe) // RULE_08
    else $error("test output driven outside shift");

  // capture step of a data scan and the output step of any shift
  sequence cap_dr_s;
    tap.rise && tap.state == bst_pkg::ST_CAP_DR;
  endsequence

  sequence fall_shift_s;
    tap.fall && shifting;
  endsequence

  sequence fall_ir_s;
    tap.fall && tap.state == bst_pkg::ST_SHIFT_IR;
  endsequence

  // boundary chain steps: capture the pins, then move one cell per rise
  bsr_capture_a: assert property (use_bsr and cap_dr_s |=> bsr == $past(pin_s2)) // RULE_02
    else $error("pin levels not captured into boundary chain");
  bsr_shift_a: assert property (use_bsr and shift_dr_s |=> // RULE_03
      bsr[BSR_LEN-1] == $past(tap.tdi) && bsr[BSR_LEN-2:0] == $past(bsr[BSR_LEN-1:1]))
    else $error("boundary chain did not shift");
  bypass_cap_a: assert property (!use_bsr and cap_dr_s |=> !bypass_bit) // RULE_05
    else $error("bypass bit did not capture zero");

  // test output: enabled in shift, showing the cell nearest the output
  tdo_drive_a: assert property (fall_shift_s |=> tdo_oe) // RULE_08
    else $error("test output not driven in shift");
  tdo_ir_a: assert property (fall_ir_s |=> tdo == $past(ir_sh[0])) // RULE_01
    else $error("instruction bit not on test output");
  tdo_bsr_a: assert property (use_bsr and fall_shift_s and !fall_ir_s // RULE_02
      |=> tdo == $past(bsr[0]))
    else $error("boundary cell not on test output");

  // controller reset always falls back to the bypass instruction
  ir_reset_a: assert property (tap.rise && tap.state == bst_pkg::ST_RESET // RULE_08
      |=> ir == bst_pkg::IR_RESET_VAL)
    else $error("reset state did not select bypass");
  core_oe_a: assert property (!extest ##1 !extest |-> pin_oe == $past(core_oe)) // RULE_02
    else $error("core enables disturbed outside external test");
endmodule

// file: verification/bst_tester.sv
/*
  external test controller model: drives the test pins and reads the test output.
  assumes a 100 MHz system clock and a test clock half period of eight system clocks.
*/
`timescale 1ns/10ps
module bst_tester #(
  parameter int W = 273 // boundary cells
) (
  input wire logic clk,   // system clock
  output logic tck,       // test clock, still between frames
  output logic tms,       // mode select level
  output logic tms_en,    // mode select driven
  output logic tdi,       // test data level
  output logic tdi_en,    // test data driven
  input wire logic tdo,   // test data out
  input wire logic tdo_oe // test data out enable
);
  logic oe_ok; // enable seen high on every shift sample
  // ==========================================
  // idle levels
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tms_en = 1'b0;
    tdi = 1'b1;
    tdi_en = 1'b0;
    oe_ok = 1'b1;
  end
  // one test clock period; lines change at the fall, tdo taken just before the rise
  task automatic tick(input logic m, input logic d, input logic men, input logic den,
                      output logic o);
    @(posedge clk);
    tck <= 1'b0;
    tms <= men ? m : ~tms; // released line toggles so only the pull-up decides
    tms_en <= men;
    tdi <= den ? d : ~tdi;
    tdi_en <= den;
    repeat (8) @(posedge clk);
    o = tdo;
    if (den)
      oe_ok = oe_ok & tdo_oe;
    tck <= 1'b1;
    repeat (7) @(posedge clk);
  endtask
  // mode select walk, first bit first
  task automatic walk(input logic [3:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      tick(seq[i], 1'b0, 1'b1, 1'b0, o);
  endtask
  // instruction load from idle, back to idle
  task automatic scan_ir(input logic [2:0] op, output logic [2:0] cap);
    walk(4'b0011, 4);
    for (int i = 0; i < 3; i++)
      tick(i == 2, op[i], 1'b1, 1'b1, cap[i]);
    walk(4'b0001, 2);
  endtask
  // data scan from idle, back to idle
  task automatic scan_dr(input logic [W-1:0] din, output logic [W-1:0] dout);
    walk(4'b0001, 3);
    for (int i = 0; i < W; i++)
      tick(i == W - 1, din[i], 1'b1, 1'b1, dout[i]);
    walk(4'b0001, 2);
  endtask
  // five clocks with mode select undriven, then to idle
  task automatic float_reset;
    logic o;
    repeat (5) tick(1'b0, 1'b0, 1'b0, 1'b0, o);
    walk(4'b0000, 1);
  endtask
endmodule

// file: verification/tb_boundary_scan_test_port.sv
/*
  self-checking bench for the boundary-scan test port.
  assumes the tester model drives all test pins; the bench drives pins and core.
*/
`timescale 1ns/10ps
module tb_boundary_scan_test_port;
  localparam int W = 273;
  localparam logic [W-1:0] PA = W'({9{32'h5A3C_96E1}});
  localparam logic [W-1:0] PB = W'({9{32'h0F1E_2D3C}});
  localparam logic [W-1:0] PC = W'({9{32'hC33C_A55A}});
  localparam logic [W-1:0] PD = W'({9{32'h1234_FEDC}});
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tms_en, tdi, tdi_en, tdo, tdo_oe;
  logic [W-1:0] pin_in, core_out, core_oe, pin_out, pin_oe, dout;
  logic [2:0] ir, cap;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  bst_top #(.BSR_LEN(W)) dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tms_en(tms_en), .tdi(tdi), .tdi_en(tdi_en), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .ir(ir));
  bst_tester #(.W(W)) tester (.clk(clk), .tck(tck), .tms(tms), .tms_en(tms_en),
    .tdi(tdi), .tdi_en(tdi_en), .tdo(tdo), .tdo_oe(tdo_oe));
  // ==========================================
  // compare and verdict
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  // reset instruction, capture value and output enable window
  task automatic t_ir;
    chk(W'(ir), W'(bst_pkg::OP_BYPASS));
    chk(W'(tdo_oe), '0);
    tester.scan_ir(bst_pkg::OP_SAMPLE, cap);
    chk(W'(cap), W'(bst_pkg::IR_CAPTURE_VAL));
    chk(W'(ir), W'(bst_pkg::OP_SAMPLE));
    chk(W'(tdo_oe), '0);
    chk(W'(tester.oe_ok), W'(1'b1));
  endtask
  // snapshot while the core keeps the pins, plus a preload
  task automatic t_sample;
    pin_in <= PA;
    core_out <= PB;
    core_oe <= PD;
    tester.scan_dr(PC, dout);
    chk(dout, PA);
    chk(pin_out, PB);
    chk(pin_oe, PD);
  endtask
  // preload reaches the pins, then a fresh pattern; core is ignored
  task automatic t_extest;
    tester.scan_ir(bst_pkg::OP_EXTEST, cap);
    chk(pin_out, PC);
    chk(pin_oe, '1);
    pin_in <= PB;
    core_out <= PA;
    tester.scan_dr(PD, dout);
    chk(dout, PB);
    chk(pin_out, PD);
  endtask
  // one-bit path for the bypass code and an unused code
  task automatic t_bypass;
    logic [2:0] ops[2];
    ops = '{bst_pkg::OP_BYPASS, 3'h3};
    foreach (ops[k]) begin
      tester.scan_ir(ops[k], cap);
      tester.scan_dr(PC, dout);
      chk(dout, {PC[W-2:0], 1'b0});
      chk(pin_out, PA);
    end
  endtask
  // undriven mode select must bring the controller back to reset
  task automatic t_float;
    tester.scan_ir(bst_pkg::OP_EXTEST, cap);
    tester.float_reset();
    chk(W'(ir), W'(bst_pkg::OP_BYPASS));
    chk(pin_out, PA);
    chk(W'(tester.oe_ok), W'(1'b1));
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    pin_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    tester.walk(4'b0000, 1);
    t_ir();
    t_sample();
    t_extest();
    t_bypass();
    t_float();
    tally_and_finish();
  end
  // a hung scan counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
